// File: cbs_bridge_regs.sv
// secondary status and bus number registers of both socket functions
// Behaviour
// (R1) Secondary parity error in address or data phase sets status bit 15.
// (R2) Event bits at 16h clear only on writing 1; writing 0 keeps them.
// (R3) Card asserting CSERR sets bit 14; the bridge never drives CSERR.
// (R4) Master abort on a bridge-initiated secondary cycle sets bit 13.
// (R5) Target abort received on a bridge-initiated cycle sets bit 12.
// (R6) Bridge ending a transaction as target with target abort sets bit 11.
// (R7) Bits 10:9 always read 01b, medium decode timing; writes ignored.
// (R8) Bit 8 sets only for CPERR, bridge master, and parity response enabled.
// (R9) Bit 7 reads 0: no fast back-to-back acceptance.
// (R10) Bit 6 reads 0: no user-definable features.
// (R11) Bit 5 reads 0: secondary clock not 66 MHz capable.
// (R12) Bits 4:0 are reserved and read zero.
// (R13) Each socket has its own status copy; events never cross sockets.
// (R14) Software writes the primary bus number at 18h; full read/write.
// (R15) Software writes the secondary bus number at 19h; full read/write.
// (R16) Forwarding decision uses primary, secondary and subordinate numbers.
// (R17) Each function keeps its own secondary bus number register.
// (R18) Software writes the subordinate bus number at 1Ah.
// (R19) Forward only when bus lies from secondary to subordinate inclusive.
`timescale 1ns/100ps
`default_nettype none

module cbs_bridge_regs (
  // clock and reset
  input  wire logic                                      clk_sys,
  input  wire logic                                      nrst,
  // configuration access
  input  wire cbs_pkg::cbs_cfg_req_t                     cfg_req,
  output var  logic                                      cfg_ack,
  output var  logic [31:0]                               cfg_rdata,
  // secondary pins, active low, asynchronous
  input  wire logic [cbs_pkg::NSOCK-1:0]                 sec_cserr_n,
  input  wire logic [cbs_pkg::NSOCK-1:0]                 sec_cperr_n,
  // secondary events from the bridge datapath
  input  wire cbs_pkg::cbs_sock_in_t [cbs_pkg::NSOCK-1:0] sock_in,
  // configuration forwarding
  input  wire cbs_pkg::cbs_fwd_req_t                     fwd_req,
  output var  cbs_pkg::cbs_fwd_rsp_t                     fwd_rsp
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [cbs_pkg::NSOCK-1:0][1:0]  cserr_sync_q;
  logic [cbs_pkg::NSOCK-1:0][1:0]  cperr_sync_q;
  logic [cbs_pkg::NSOCK-1:0][1:0]  mst_dly_q;
  cbs_pkg::cbs_evt_t [cbs_pkg::NSOCK-1:0] evt;
  logic [cbs_pkg::NSOCK-1:0]       wr_sel;
  logic [cbs_pkg::NSOCK-1:0]       clr_we;
  logic [cbs_pkg::NSOCK-1:0][15:0] clr_data;
  logic [cbs_pkg::NSOCK-1:0][15:0] status;
  logic [cbs_pkg::NSOCK-1:0][7:0]  pri_bus_q;
  logic [cbs_pkg::NSOCK-1:0][7:0]  sec_bus_q;
  logic [cbs_pkg::NSOCK-1:0][7:0]  sub_bus_q;
  logic [31:0]                     rdata_d;
  logic [7:0]                      f_pri;
  logic [7:0]                      f_sec;
  logic [7:0]                      f_sub;
  logic                            fwd_hit;
  logic                            fwd_own;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------------
  // per-socket logic
  // ------------------------------------------------------------------
  generate
    for (genvar s = 0; s < cbs_pkg::NSOCK; s++) begin : g_sock

      // pin synchronisers, first stage feeds only the second
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          cserr_sync_q[s] <= cbs_pkg::SYNC_IDLE;
          cperr_sync_q[s] <= cbs_pkg::SYNC_IDLE;
        end else begin
          cserr_sync_q[s] <= {cserr_sync_q[s][0], sec_cserr_n[s]};
          cperr_sync_q[s] <= {cperr_sync_q[s][0], sec_cperr_n[s]};
        end
      end

      // master flag delayed to line up with the synchronised error pin
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          mst_dly_q[s] <= cbs_pkg::DLY_RESET;
        end else begin
          mst_dly_q[s] <= {mst_dly_q[s][0], sock_in[s].master_dphase};
        end
      end

      // events of this socket only
      always_comb begin
        evt[s].parity = sock_in[s].addr_perr | sock_in[s].data_perr; // R1
        evt[s].serr   = ~cserr_sync_q[s][1]; // R3
        evt[s].mabort = sock_in[s].mabort; // R4
        evt[s].ta_rcv = sock_in[s].ta_rcv; // R5
        evt[s].ta_sig = sock_in[s].ta_sig; // R6
        evt[s].dpar   = ~cperr_sync_q[s][1] & mst_dly_q[s][1]
                        & sock_in[s].perr_resp_en; // R8
      end

      // write decode for this function
      assign wr_sel[s]   = cfg_req.valid & cfg_req.write
                           & (cfg_req.func == 1'(s)); // R13 R17
      assign clr_we[s]   = wr_sel[s] & (cfg_req.dw == cbs_pkg::DW_STATUS)
                           & cfg_req.be[cbs_pkg::LN_ST_LO + 1];
      assign clr_data[s] = cfg_req.wdata[cbs_pkg::SH_STATUS +: 16]; // R2

      cbs_status_reg u_status (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .evt      (evt[s]),
        .clr_we   (clr_we[s]),
        .clr_data (clr_data[s]),
        .status_q (status[s])
      );

      // bus number registers, byte-lane writes
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          pri_bus_q[s] <= cbs_pkg::BUSNUM_RESET;
          sec_bus_q[s] <= cbs_pkg::BUSNUM_RESET;
          sub_bus_q[s] <= cbs_pkg::BUSNUM_RESET;
        end else if (wr_sel[s] && cfg_req.dw == cbs_pkg::DW_BUSNUM) begin
          if (cfg_req.be[cbs_pkg::LN_PRI]) begin
            pri_bus_q[s] <= cfg_req.wdata[8*cbs_pkg::LN_PRI +: 8];
          end
          if (cfg_req.be[cbs_pkg::LN_SEC]) begin
            sec_bus_q[s] <= cfg_req.wdata[8*cbs_pkg::LN_SEC +: 8]; // R17
          end
          if (cfg_req.be[cbs_pkg::LN_SUB]) begin
            sub_bus_q[s] <= cfg_req.wdata[8*cbs_pkg::LN_SUB +: 8];
          end
        end
      end

      // checks of this socket
      a_parity_sets: // R1
        assert property (evt[s].parity |=> status[s][cbs_pkg::B_PARITY])
        else $error("parity error not recorded");
      a_serr_sets: // R3
        assert property (!cserr_sync_q[s][1]
                         |=> status[s][cbs_pkg::B_SERR])
        else $error("card system error not recorded");
      a_mabort_sets: // R4
        assert property (sock_in[s].mabort
                         |=> status[s][cbs_pkg::B_MABORT])
        else $error("master abort not recorded");
      a_ta_rcv_sets: // R5
        assert property (sock_in[s].ta_rcv
                         |=> status[s][cbs_pkg::B_TA_RCV])
        else $error("received target abort not recorded");
      a_ta_sig_sets: // R6
        assert property (sock_in[s].ta_sig
                         |=> status[s][cbs_pkg::B_TA_SIG])
        else $error("signalled target abort not recorded");
      a_devsel_fixed: // R7
        assert property (status[s][cbs_pkg::B_DEV_MSB:cbs_pkg::B_DEV_LSB]
                         == cbs_pkg::DEVSEL_MEDIUM)
        else $error("decode timing field not 01b");
      a_dpar_cause: // R8
        assert property ($rose(status[s][cbs_pkg::B_DPAR])
                         |-> $past(!sec_cperr_n[s], 3)
                             && $past(sock_in[s].master_dphase, 3)
                             && $past(sock_in[s].perr_resp_en))
        else $error("data parity bit set without its conditions");
      a_low_bits_zero: // R9 R10 R11 R12
        assert property (!status[s][cbs_pkg::B_FBB]
                         && !status[s][cbs_pkg::B_UDF]
                         && !status[s][cbs_pkg::B_FAST_CLK]
                         && status[s][cbs_pkg::B_RSVD_MSB:0] == '0)
        else $error("hardwired zero bits not zero");
      a_w1c_clears: // R2
        assert property (clr_we[s] && clr_data[s][cbs_pkg::B_MABORT]
                         && !sock_in[s].mabort
                         |=> !status[s][cbs_pkg::B_MABORT])
        else $error("write of one did not clear");
      a_zero_write_holds: // R2
        assert property (clr_we[s] && !clr_data[s][cbs_pkg::B_TA_SIG]
                         && status[s][cbs_pkg::B_TA_SIG]
                         |=> status[s][cbs_pkg::B_TA_SIG])
        else $error("write of zero cleared a bit");
      a_socket_isolated: // R13
        assert property (evt[s] == '0 && !clr_we[s]
                         |=> $stable(status[s]))
        else $error("status changed without own event or write");
      a_secbus_write: // R15 R17
        assert property (wr_sel[s] && cfg_req.dw == cbs_pkg::DW_BUSNUM
                         && cfg_req.be[cbs_pkg::LN_SEC]
                         |=> sec_bus_q[s]
                             == $past(cfg_req.wdata[8*cbs_pkg::LN_SEC +: 8]))
        else $error("secondary bus number not written");
      a_pribus_write: // R14
        assert property (wr_sel[s] && cfg_req.dw == cbs_pkg::DW_BUSNUM
                         && cfg_req.be[cbs_pkg::LN_PRI]
                         |=> pri_bus_q[s]
                             == $past(cfg_req.wdata[8*cbs_pkg::LN_PRI +: 8]))
        else $error("primary bus number not written");
      a_subbus_write: // R18
        assert property (wr_sel[s] && cfg_req.dw == cbs_pkg::DW_BUSNUM
                         && cfg_req.be[cbs_pkg::LN_SUB]
                         |=> sub_bus_q[s]
                             == $past(cfg_req.wdata[8*cbs_pkg::LN_SUB +: 8]))
        else $error("subordinate bus number not written");
      c_parity_then_clear:
        cover property (status[s][cbs_pkg::B_PARITY] ##1 clr_we[s]
                        ##1 !status[s][cbs_pkg::B_PARITY]);
    end
  endgenerate

  // ------------------------------------------------------------------
  // configuration read path
  // ------------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (cfg_req.dw == cbs_pkg::DW_STATUS) begin
      rdata_d[cbs_pkg::SH_STATUS +: 16] = status[cfg_req.func];
    end else if (cfg_req.dw == cbs_pkg::DW_BUSNUM) begin
      rdata_d[8*cbs_pkg::LN_PRI +: 8] = pri_bus_q[cfg_req.func]; // R14
      rdata_d[8*cbs_pkg::LN_SEC +: 8] = sec_bus_q[cfg_req.func]; // R15
      rdata_d[8*cbs_pkg::LN_SUB +: 8] = sub_bus_q[cfg_req.func]; // R18
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= '0;
    end else begin
      cfg_ack   <= cfg_req.valid;
      cfg_rdata <= (cfg_req.valid && !cfg_req.write) ? rdata_d : '0;
    end
  end

  // ------------------------------------------------------------------
  // configuration forwarding decision
  // ------------------------------------------------------------------
  assign f_pri   = pri_bus_q[fwd_req.func];
  assign f_sec   = sec_bus_q[fwd_req.func];
  assign f_sub   = sub_bus_q[fwd_req.func];
  assign fwd_own = (fwd_req.bus == f_pri); // R16
  assign fwd_hit = !fwd_own && (fwd_req.bus >= f_sec)
                   && (fwd_req.bus <= f_sub); // R16 R19

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fwd_rsp <= '0;
    end else begin
      fwd_rsp.done  <= fwd_req.valid;
      fwd_rsp.claim <= fwd_req.valid & fwd_hit; // R19
      fwd_rsp.type0 <= fwd_req.valid & fwd_hit & (fwd_req.bus == f_sec);
    end
  end

  a_fwd_outside: // R19
    assert property (fwd_req.valid
                     && (fwd_req.bus < f_sec || fwd_req.bus > f_sub)
                     |=> fwd_rsp.done && !fwd_rsp.claim)
    else $error("out of range bus forwarded");
  a_fwd_primary: // R16
    assert property (fwd_req.valid && fwd_req.bus == f_pri
                     |=> !fwd_rsp.claim)
    else $error("primary bus cycle forwarded");
  a_fwd_inside: // R19
    assert property (fwd_req.valid && fwd_req.bus != f_pri
                     && fwd_req.bus >= f_sec && fwd_req.bus <= f_sub
                     |=> fwd_rsp.claim)
    else $error("in range bus not forwarded");
  a_fwd_type0: // R16
    assert property (fwd_rsp.type0 |-> fwd_rsp.claim
                     && $past(fwd_req.bus) == $past(f_sec))
    else $error("type 0 given for wrong bus");
  a_read_timing:
    assert property (cfg_req.valid |=> cfg_ack)
    else $error("configuration access not answered");
  a_write_no_data:
    assert property (cfg_req.valid && cfg_req.write |=> cfg_rdata == '0)
    else $error("read data driven on a write");
  a_fwd_done: // R19
    assert property (fwd_req.valid |=> fwd_rsp.done)
    else $error("forwarding request not answered");
  a_status_readback: // R7 R13
    assert property (cfg_req.valid && !cfg_req.write
                     && cfg_req.dw == cbs_pkg::DW_STATUS
                     |=> cfg_rdata[cbs_pkg::SH_STATUS +: 16]
                         == $past(status[cfg_req.func]))
    else $error("status read returned wrong copy");
  a_unmapped_zero:
    assert property (cfg_req.valid && !cfg_req.write
                     && cfg_req.dw != cbs_pkg::DW_STATUS
                     && cfg_req.dw != cbs_pkg::DW_BUSNUM
                     |=> cfg_rdata == '0)
    else $error("unmapped offset read not zero");

  c_fwd_type0:
    cover property (fwd_req.valid ##1 fwd_rsp.type0);
  c_fwd_deeper:
    cover property (fwd_req.valid ##1 fwd_rsp.claim && !fwd_rsp.type0);
  c_status_read:
    cover property (cfg_req.valid && !cfg_req.write
                    && cfg_req.dw == cbs_pkg::DW_STATUS ##1 cfg_ack);

endmodule

`default_nettype wire

// File: cbs_pkg.sv
// shared constants and carrier types of the secondary status and bus numbers
package cbs_pkg;

  // ------------------------------------------------------------------
  // sockets
  // ------------------------------------------------------------------
  localparam int NSOCK = 2;

  // ------------------------------------------------------------------
  // configuration offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_SEC_STATUS = 8'h16;
  localparam logic [7:0] OFS_PRI_BUS    = 8'h18;
  localparam logic [7:0] OFS_SEC_BUS    = 8'h19;
  localparam logic [7:0] OFS_SUB_BUS    = 8'h1A;

  localparam logic [5:0] DW_STATUS = OFS_SEC_STATUS[7:2];
  localparam logic [5:0] DW_BUSNUM = OFS_PRI_BUS[7:2];
  localparam int SH_STATUS = 8 * int'(OFS_SEC_STATUS[1:0]);
  localparam int LN_PRI    = int'(OFS_PRI_BUS[1:0]);
  localparam int LN_SEC    = int'(OFS_SEC_BUS[1:0]);
  localparam int LN_SUB    = int'(OFS_SUB_BUS[1:0]);
  localparam int LN_ST_LO  = int'(OFS_SEC_STATUS[1:0]);

  // ------------------------------------------------------------------
  // status field layout and reset values
  // ------------------------------------------------------------------
  localparam int B_PARITY   = 15;
  localparam int B_SERR     = 14;
  localparam int B_MABORT   = 13;
  localparam int B_TA_RCV   = 12;
  localparam int B_TA_SIG   = 11;
  localparam int B_DEV_MSB  = 10;
  localparam int B_DEV_LSB  = 9;
  localparam int B_DPAR     = 8;
  localparam int B_FBB      = 7;
  localparam int B_UDF      = 6;
  localparam int B_FAST_CLK = 5;
  localparam int B_RSVD_MSB = 4;

  localparam logic [1:0]  DEVSEL_MEDIUM   = 2'h1;
  localparam logic [15:0] STATUS_RESET    = 16'h0200;
  localparam logic [15:0] STATUS_FIXED    = 16'h0200;
  localparam logic [15:0] STATUS_W1C_MASK = 16'hF900;
  localparam logic [7:0]  BUSNUM_RESET    = 8'h00;
  localparam logic [1:0]  SYNC_IDLE       = 2'h3;
  localparam logic [1:0]  DLY_RESET       = 2'h0;

  // ------------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic parity;
    logic serr;
    logic mabort;
    logic ta_rcv;
    logic ta_sig;
    logic dpar;
  } cbs_evt_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        func;
    logic [5:0]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cbs_cfg_req_t;

  typedef struct packed {
    logic addr_perr;
    logic data_perr;
    logic mabort;
    logic ta_rcv;
    logic ta_sig;
    logic master_dphase;
    logic perr_resp_en;
  } cbs_sock_in_t;

  typedef struct packed {
    logic       valid;
    logic       func;
    logic [7:0] bus;
  } cbs_fwd_req_t;

  typedef struct packed {
    logic done;
    logic claim;
    logic type0;
  } cbs_fwd_rsp_t;

endpackage

// File: cbs_status_reg.sv
// one socket's secondary error status register
`timescale 1ns/100ps
`default_nettype none

module cbs_status_reg (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // hardware events
  input  wire cbs_pkg::cbs_evt_t evt,
  // software write-one-to-clear
  input  wire logic              clr_we,
  input  wire logic [15:0]       clr_data,
  // register value
  output var  logic [15:0]       status_q
);

  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [15:0] status_d;

  // ------------------------------------------------------------------
  // event and clear vectors
  // ------------------------------------------------------------------
  always_comb begin
    set_v = '0;
    set_v[cbs_pkg::B_PARITY] = evt.parity;
    set_v[cbs_pkg::B_SERR]   = evt.serr;
    set_v[cbs_pkg::B_MABORT] = evt.mabort;
    set_v[cbs_pkg::B_TA_RCV] = evt.ta_rcv;
    set_v[cbs_pkg::B_TA_SIG] = evt.ta_sig;
    set_v[cbs_pkg::B_DPAR]   = evt.dpar;
    clr_v = clr_we ? (clr_data & cbs_pkg::STATUS_W1C_MASK) : '0; // R2
    // set beats a clear in the same cycle
    status_d = (((status_q & ~clr_v) | set_v) & cbs_pkg::STATUS_W1C_MASK)
               | cbs_pkg::STATUS_FIXED; // R7 R9 R10 R11 R12
  end

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_q <= cbs_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

endmodule

`default_nettype wire

// File: cbs_card_model.sv
// card-side model driving the secondary error pins of both sockets
`timescale 1ns/100ps
`default_nettype none

module cbs_card_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // one-cycle commands from the bench, one bit a socket
  input  wire logic [1:0] serr_req,
  input  wire logic [1:0] perr_req,
  // card pins, driven low while a pulse runs and driven high otherwise
  output var  logic [1:0] sec_cserr_n,
  output var  logic [1:0] sec_cperr_n
);
  // ------------------------------------------------------------------
  // pin pulse shapers, three cycles low per command
  // ------------------------------------------------------------------
  logic [1:0][2:0] serr_sh_q;
  logic [1:0][2:0] perr_sh_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serr_sh_q <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        serr_sh_q[s] <= serr_req[s] ? 3'h7 : (serr_sh_q[s] >> 1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      perr_sh_q <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        perr_sh_q[s] <= perr_req[s] ? 3'h7 : (perr_sh_q[s] >> 1);
      end
    end
  end

  // released pins are driven high, the idle level
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      sec_cserr_n[s] = ~serr_sh_q[s][0];
      sec_cperr_n[s] = ~perr_sh_q[s][0];
    end
  end
endmodule

`default_nettype wire

// File: cbs_bridge_regs_tb_top.sv
// self-checking bench of the secondary status and bus number registers
`timescale 1ns/100ps
`default_nettype none

module cbs_bridge_regs_tb_top;
  logic                                        clk_sys;
  logic                                        nrst;
  cbs_pkg::cbs_cfg_req_t                       cfg_req;
  logic                                        cfg_ack;
  logic [31:0]                                 cfg_rdata;
  logic [1:0]                                  sec_cserr_n;
  logic [1:0]                                  sec_cperr_n;
  cbs_pkg::cbs_sock_in_t [cbs_pkg::NSOCK-1:0]  sock_in;
  cbs_pkg::cbs_fwd_req_t                       fwd_req;
  cbs_pkg::cbs_fwd_rsp_t                       fwd_rsp;
  logic [1:0]                                  serr_req;
  logic [1:0]                                  perr_req;
  int                                          errors;
  int                                          num_checks;
  int                                          cycles;

  cbs_bridge_regs i_dut (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .cfg_req     (cfg_req),
    .cfg_ack     (cfg_ack),
    .cfg_rdata   (cfg_rdata),
    .sec_cserr_n (sec_cserr_n),
    .sec_cperr_n (sec_cperr_n),
    .sock_in     (sock_in),
    .fwd_req     (fwd_req),
    .fwd_rsp     (fwd_rsp)
  );

  cbs_card_model i_card (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .serr_req    (serr_req),
    .perr_req    (perr_req),
    .sec_cserr_n (sec_cserr_n),
    .sec_cperr_n (sec_cperr_n)
  );

  // ------------------------------------------------------------------
  // common tasks
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg(input logic wr, input logic fn, input logic [5:0] dw,
                     input logic [3:0] be, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    cfg_req <= '{valid:1'b1, write:wr, func:fn, dw:dw, be:be, wdata:wd};
    @(posedge clk_sys);
    cfg_req.valid <= 1'b0;
    #1;
    check({31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
  endtask

  task automatic rd_chk(input logic fn, input logic [5:0] dw,
                        input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] rd;
    cfg(1'b0, fn, dw, 4'hF, 32'h0, rd);
    check(rd & mask, exp);
  endtask

  task automatic wr(input logic fn, input logic [5:0] dw,
                    input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] rd;
    cfg(1'b1, fn, dw, be, wd, rd);
  endtask

  task automatic fwd(input logic fn, input logic [7:0] b,
                     input logic [7:0] pri, input logic [7:0] sec,
                     input logic [7:0] sub);
    logic cl;
    cl = (b != pri) && (b >= sec) && (b <= sub);
    @(posedge clk_sys);
    fwd_req <= '{valid:1'b1, func:fn, bus:b};
    @(posedge clk_sys);
    fwd_req.valid <= 1'b0;
    #1;
    check({29'h0, fwd_rsp}, {29'h0, 1'b1, cl, cl && (b == sec)});
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_and_ro();
    for (int f = 0; f < 2; f++) begin
      rd_chk(f[0], 6'h05, 32'hFFFF_FFFF, 32'h0200_0000);
      rd_chk(f[0], 6'h06, 32'hFFFF_FFFF, 32'h0);
    end
    wr(1'b0, 6'h05, 4'hF, 32'hFFFF_FFFF);
    rd_chk(1'b0, 6'h05, 32'hFFFF_FFFF, 32'h0200_0000);
    rd_chk(1'b0, 6'h00, 32'hFFFF_FFFF, 32'h0);
  endtask

  task automatic test_bus_numbers();
    wr(1'b0, 6'h06, 4'hF, 32'hFF04_0201);
    wr(1'b1, 6'h06, 4'h7, 32'h0005_0203);
    rd_chk(1'b0, 6'h06, 32'hFFFF_FFFF, 32'h0004_0201);
    rd_chk(1'b1, 6'h06, 32'hFFFF_FFFF, 32'h0005_0203);
  endtask

  task automatic test_events();
    int bits [5] = '{15, 15, 13, 12, 11};
    logic [31:0] m;
    for (int i = 0; i < 5; i++) begin
      m = 32'h1 << (bits[i] + 16);
      @(posedge clk_sys);
      sock_in[1] <= cbs_pkg::cbs_sock_in_t'(7'h40 >> i);
      @(posedge clk_sys);
      sock_in[1] <= '0;
      rd_chk(1'b1, 6'h05, 32'hFFFF_FFFF, 32'h0200_0000 | m);
      rd_chk(1'b0, 6'h05, 32'hFFFF_FFFF, 32'h0200_0000);
      wr(1'b1, 6'h05, 4'hC, 32'h0);
      rd_chk(1'b1, 6'h05, m, m);
      wr(1'b1, 6'h05, 4'hC, m);
      rd_chk(1'b1, 6'h05, 32'hFFFF_FFFF, 32'h0200_0000);
    end
  endtask

  task automatic test_card_pins();
    logic [6:0] mode [3] = '{7'h03, 7'h02, 7'h01};
    @(posedge clk_sys);
    serr_req <= 2'h1;
    @(posedge clk_sys);
    serr_req <= 2'h0;
    repeat (5) @(posedge clk_sys);
    rd_chk(1'b0, 6'h05, 32'hFFFF_FFFF, 32'h4200_0000);
    rd_chk(1'b1, 6'h05, 32'hFFFF_FFFF, 32'h0200_0000);
    wr(1'b0, 6'h05, 4'hC, 32'hFFFF_0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      sock_in[0] <= cbs_pkg::cbs_sock_in_t'(mode[i]);
      perr_req <= 2'h1;
      @(posedge clk_sys);
      perr_req <= 2'h0;
      repeat (7) @(posedge clk_sys);
      sock_in[0] <= '0;
      rd_chk(1'b0, 6'h05, 32'h0100_0000, {7'h0, i == 0, 24'h0});
      wr(1'b0, 6'h05, 4'hC, 32'hFFFF_0000);
    end
  endtask

  task automatic test_forwarding();
    for (int b = 0; b < 6; b++) begin
      fwd(1'b0, b[7:0], 8'h01, 8'h02, 8'h04);
      fwd(1'b1, b[7:0], 8'h03, 8'h02, 8'h05);
    end
  endtask

  // ------------------------------------------------------------------
  // clock, timeout and main sequence
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    errors = 0;
    num_checks = 0;
    cycles = 0;
    nrst = 1'b0;
    cfg_req = '0;
    sock_in = '0;
    fwd_req = '0;
    serr_req = 2'h0;
    perr_req = 2'h0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    test_reset_and_ro();
    test_bus_numbers();
    test_events();
    test_card_pins();
    test_forwarding();
    stop_test();
  end
endmodule

`default_nettype wire
